// ### src/acl_entry_access.sv
// per-port filter-entry indirect access: selector, offset, data byte, holding
// buffers, byte-select masks, 16-entry tables and ring-redundancy mode bits.
// assumes a synchronous byte register port on i_clk_sys; ring match inputs
// come from logic on the same clock.
//
// Behaviour
// [RULE_01] selector bits [7:5] must be 010 for accesses to reach the filter table.
// [RULE_02] selector bits [3:0] pick port 1 to 5 whose register set is addressed.
// [RULE_03] the offset register picks a byte of that set and the data byte at 0xa0 carries it.
// [RULE_04] a 16-bit membership field, holding bytes 0x0c and 0x0d, marks entries of the rule set.
// [RULE_05] a 14-bit byte-select mask picks which entry bytes a transfer moves.
// [RULE_06] mask bit 0 governs entry byte 0x0d and bit 13 governs byte 0x00.
// [RULE_07] control bit 5 is read-only, one when the last read is done, one after reset.
// [RULE_08] control bit 4 selects write (1) or read (0) and resets to zero.
// [RULE_09] control bits [3:0] give the target entry 0 to 15 in binary.
// [RULE_10] with force-miss set, a packet matching the single entry counts as a miss.
// [RULE_11] with force-miss clear, a packet matching the rule set counts as a hit.
// [RULE_12] control bit 6 shows the previous write is done and is polled before loading bytes.
// [RULE_13] a write copies mask-selected bytes into the entry and leaves the others alone.
// [RULE_14] writing the control register launches the transfer and clears its done flag meanwhile.
// [RULE_15] reserved bits read as zero.
`default_nettype none
`include "acl_params.svh"

module acl_entry_access (
  input  wire logic       i_clk_sys,
  input  wire logic       i_rst,
  input  wire logic [7:0] i_reg_addr,
  input  wire logic [7:0] i_reg_wdata,
  input  wire logic       i_reg_wr,
  input  wire logic       i_reg_rd,
  output logic      [7:0] o_reg_rdata,
  input  wire logic [2:0] i_ring_port,
  input  wire logic       i_ring_entry_match,
  input  wire logic       i_ring_set_match,
  output logic            o_ring_hit,
  output logic            o_ring_miss
);

  // ----------------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------------
  function automatic logic acl_port_ok(input logic [7:0] s);
    return (s[7:5] == `ACL_SEL_TABLE) &&
           (s[3:0] >= `ACL_PORT_MIN) && (s[3:0] <= `ACL_PORT_MAX); // RULE_01
  endfunction

  function automatic logic [2:0] acl_port_idx(input logic [7:0] s);
    logic [3:0] t;
    t = s[3:0] - `ACL_PORT_MIN; // RULE_02
    return t[2:0];
  endfunction

  acl_pkg::acl_regs_t q;
  acl_pkg::acl_regs_t d;
  logic               pok;
  logic [2:0]         pi;
  logic [7:0]         ind_byte;
  logic [3:0]         mbit;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    d        = q;
    pok      = acl_port_ok(q.sel);
    pi       = acl_port_idx(q.sel);
    mbit     = `ACL_LAST_BYTE - q.cnt; // RULE_06
    ind_byte = `ACL_RST_BYTE;

    // indirect byte view; reserved bits and unmapped offsets read zero
    if (pok) begin
      if (q.off <= `ACL_O_LAST) begin
        ind_byte = q.hold[pi][q.off[3:0]]; // RULE_03 RULE_04
      end else begin
        case (q.off)
          `ACL_O_MASK_HI: ind_byte = {2'b00, q.mask[pi][13:8]}; // RULE_15
          `ACL_O_MASK_LO: ind_byte = q.mask[pi][7:0];
          `ACL_O_CTRL:    ind_byte = {1'b0, q.wr_done[pi], q.rd_done[pi],
                                      q.dir[pi], q.idx[pi]}; // RULE_07 RULE_12 RULE_15
          `ACL_O_RING:    ind_byte = {7'h00, q.ring[pi]}; // RULE_15
          default:        ind_byte = `ACL_RST_BYTE;
        endcase
      end
    end

    if (i_reg_rd) begin
      case (i_reg_addr)
        `ACL_A_SEL:  d.rdata = q.sel;
        `ACL_A_OFF:  d.rdata = q.off;
        `ACL_A_DATA: d.rdata = ind_byte; // RULE_03
        default:     d.rdata = `ACL_RST_BYTE;
      endcase
    end

    if (i_reg_wr) begin
      case (i_reg_addr)
        `ACL_A_SEL: d.sel = i_reg_wdata;
        `ACL_A_OFF: d.off = i_reg_wdata;
        `ACL_A_DATA: begin
          if (pok) begin
            if (q.off <= `ACL_O_LAST) begin
              d.hold[pi][q.off[3:0]] = i_reg_wdata; // RULE_03 RULE_04
            end else begin
              case (q.off)
                `ACL_O_MASK_HI: d.mask[pi][13:8] = i_reg_wdata[5:0]; // RULE_05
                `ACL_O_MASK_LO: d.mask[pi][7:0]  = i_reg_wdata;
                `ACL_O_CTRL: begin
                  // a launch while busy is dropped whole so that the running
                  // transfer keeps its entry index
                  if (q.st == acl_pkg::ST_IDLE) begin
                    d.dir[pi]  = i_reg_wdata[`ACL_B_DIR]; // RULE_08
                    d.idx[pi]  = i_reg_wdata[3:0]; // RULE_09
                    d.port     = pi;
                    d.cnt      = 4'h0;
                    if (i_reg_wdata[`ACL_B_DIR]) begin
                      d.st         = acl_pkg::ST_WR;
                      d.wr_done[pi] = 1'b0; // RULE_14
                    end else begin
                      d.st         = acl_pkg::ST_RD;
                      d.rd_done[pi] = 1'b0; // RULE_14
                    end
                  end
                end
                `ACL_O_RING: d.ring[pi] = i_reg_wdata[0];
                default: ;
              endcase
            end
          end
        end
        default: ;
      endcase
    end

    // one entry byte per cycle; the transfer wins over a bus write to the
    // same holding byte
    case (q.st)
      acl_pkg::ST_IDLE: ;
      acl_pkg::ST_RD: begin
        if (q.mask[q.port][mbit]) begin
          d.hold[q.port][q.cnt] = q.tbl[q.port][q.idx[q.port]][q.cnt]; // RULE_05
        end
        if (q.cnt == `ACL_LAST_BYTE) begin
          d.st              = acl_pkg::ST_IDLE;
          d.rd_done[q.port] = 1'b1; // RULE_07
        end else begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      acl_pkg::ST_WR: begin
        if (q.mask[q.port][mbit]) begin
          d.tbl[q.port][q.idx[q.port]][q.cnt] = q.hold[q.port][q.cnt]; // RULE_13
        end
        if (q.cnt == `ACL_LAST_BYTE) begin
          d.st              = acl_pkg::ST_IDLE;
          d.wr_done[q.port] = 1'b1; // RULE_12
        end else begin
          d.cnt = q.cnt + 4'h1;
        end
      end
      default: d.st = acl_pkg::ST_IDLE;
    endcase

    // ring-redundancy verdict for the port the filter is working on
    if (i_ring_port < 3'(`ACL_NPORT)) begin
      d.hit  = !q.ring[i_ring_port] && i_ring_set_match; // RULE_11
      d.miss = q.ring[i_ring_port] && i_ring_entry_match; // RULE_10
    end else begin
      d.hit  = 1'b0;
      d.miss = 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // state register
  // ----------------------------------------------------------------------
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      q         <= '0;
      q.rd_done <= {`ACL_NPORT{`ACL_RST_RDONE}};
      q.wr_done <= {`ACL_NPORT{`ACL_RST_WDONE}};
      q.st      <= acl_pkg::ST_IDLE;
    end else begin
      q <= d;
    end
  end

  assign o_reg_rdata = q.rdata;
  assign o_ring_hit  = q.hit;
  assign o_ring_miss = q.miss;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);

  logic       ctl_wr;
  logic [7:0] tbl_cur;
  logic [3:0] busy_len_q;

  assign ctl_wr  = i_reg_wr && (i_reg_addr == `ACL_A_DATA) && pok &&
                   (q.off == `ACL_O_CTRL) && (q.st == acl_pkg::ST_IDLE);
  assign tbl_cur = q.tbl[q.port][q.idx[q.port]][q.cnt];

  // cycles spent in the running transfer; long holds are checked on this
  // count so that no property needs a long repetition
  always_ff @(posedge i_clk_sys or posedge i_rst) begin
    if (i_rst) begin
      busy_len_q <= 4'h0;
    end else if (q.st == acl_pkg::ST_IDLE) begin
      busy_len_q <= 4'h0;
    end else begin
      busy_len_q <= busy_len_q + 4'h1;
    end
  end

  sequence seq_rd_launch;
    ctl_wr && !i_reg_wdata[`ACL_B_DIR];
  endsequence

  sequence seq_wr_launch;
    ctl_wr && i_reg_wdata[`ACL_B_DIR];
  endsequence

  launch_clears_rd_a: assert property ( // RULE_14
    seq_rd_launch |=> (q.st == acl_pkg::ST_RD) && !q.rd_done[q.port])
    else $error("read launch did not clear done");
  launch_clears_wr_a: assert property ( // RULE_14
    seq_wr_launch |=> (q.st == acl_pkg::ST_WR) && !q.wr_done[q.port])
    else $error("write launch did not clear done");
  rd_flag_low_a: assert property ( // RULE_07
    (q.st == acl_pkg::ST_RD) |-> !q.rd_done[q.port])
    else $error("read done set while reading");
  wr_flag_low_a: assert property ( // RULE_12
    (q.st == acl_pkg::ST_WR) |-> !q.wr_done[q.port])
    else $error("write done set while writing");
  busy_bounded_a: assert property ( // RULE_05
    (q.st != acl_pkg::ST_IDLE) |-> (busy_len_q <= `ACL_LAST_BYTE))
    else $error("transfer ran past the last entry byte");
  read_done_time_a: assert property ( // RULE_07
    seq_rd_launch |=> ##13 ((q.st == acl_pkg::ST_RD) && (busy_len_q == `ACL_LAST_BYTE))
    ##1 ((q.st == acl_pkg::ST_IDLE) && q.rd_done[q.port]))
    else $error("read done not after 14 cycles");
  write_done_time_a: assert property ( // RULE_12
    seq_wr_launch |=> ##13 ((q.st == acl_pkg::ST_WR) && (busy_len_q == `ACL_LAST_BYTE))
    ##1 ((q.st == acl_pkg::ST_IDLE) && q.wr_done[q.port]))
    else $error("write done not after 14 cycles");
  wr_unselected_kept_a: assert property ( // RULE_13
    (q.st == acl_pkg::ST_WR) && !q.mask[q.port][mbit]
    |=> q.tbl[$past(q.port)][$past(q.idx[q.port])][$past(q.cnt)] == $past(tbl_cur))
    else $error("unselected entry byte changed");
  wr_selected_copy_a: assert property ( // RULE_05
    (q.st == acl_pkg::ST_WR) && q.mask[q.port][mbit]
    |=> q.tbl[$past(q.port)][$past(q.idx[q.port])][$past(q.cnt)] ==
        $past(q.hold[q.port][q.cnt]))
    else $error("selected byte not written");
  ctrl_reserved_a: assert property ( // RULE_15
    i_reg_rd && (i_reg_addr == `ACL_A_DATA) && pok && (q.off == `ACL_O_CTRL)
    |=> !o_reg_rdata[7])
    else $error("ctrl bit 7 not zero");
  force_miss_a: assert property ( // RULE_10
    (i_ring_port < 3'(`ACL_NPORT)) && q.ring[i_ring_port]
    |=> !o_ring_hit && (o_ring_miss == $past(i_ring_entry_match)))
    else $error("force-miss verdict wrong");
  set_hit_a: assert property ( // RULE_11
    (i_ring_port < 3'(`ACL_NPORT)) && !q.ring[i_ring_port]
    |=> !o_ring_miss && (o_ring_hit == $past(i_ring_set_match)))
    else $error("rule-set verdict wrong");
  bad_sel_ignored_a: assert property ( // RULE_01
    i_reg_wr && (i_reg_addr == `ACL_A_DATA) && !pok
    |=> $stable(q.mask) && $stable(q.ring))
    else $error("write with bad selector took effect");

endmodule

`default_nettype wire

// ### src/acl_params.svh
// named constants for the per-port filter-entry indirect access block
// assumes inclusion from the package and the design file only
`ifndef ACL_PARAMS_SVH
`define ACL_PARAMS_SVH

`define ACL_NPORT      5
`define ACL_NBYTE      14
`define ACL_NENT       16
`define ACL_A_SEL      8'h6e
`define ACL_A_OFF      8'h6f
`define ACL_A_DATA     8'ha0
`define ACL_SEL_TABLE  3'b010
`define ACL_PORT_MIN   4'h1
`define ACL_PORT_MAX   4'h5
`define ACL_O_LAST     8'h0d
`define ACL_O_MASK_HI  8'h10
`define ACL_O_MASK_LO  8'h11
`define ACL_O_CTRL     8'h12
`define ACL_O_RING     8'h13
`define ACL_B_DIR      4
`define ACL_LAST_BYTE  4'hd
`define ACL_RST_BYTE   8'h00
`define ACL_RST_MASK   14'h0000
`define ACL_RST_IDX    4'h0
`define ACL_RST_RDONE  1'b1
`define ACL_RST_WDONE  1'b1

`endif

// ### src/acl_pkg.sv
// types of the filter-entry indirect access block
// assumes acl_params.svh on the include path
`default_nettype none
`include "acl_params.svh"

package acl_pkg;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_RD   = 3'b010,
    ST_WR   = 3'b100
  } acl_state_t;

  typedef logic [`ACL_NBYTE-1:0][7:0] acl_entry_t;

  typedef struct packed {
    logic [7:0]                                 sel;
    logic [7:0]                                 off;
    logic [7:0]                                 rdata;
    acl_entry_t [`ACL_NPORT-1:0]                hold;
    acl_entry_t [`ACL_NPORT-1:0][`ACL_NENT-1:0] tbl;
    logic [`ACL_NPORT-1:0][`ACL_NBYTE-1:0]      mask;
    logic [`ACL_NPORT-1:0]                      dir;
    logic [`ACL_NPORT-1:0][3:0]                 idx;
    logic [`ACL_NPORT-1:0]                      rd_done;
    logic [`ACL_NPORT-1:0]                      wr_done;
    logic [`ACL_NPORT-1:0]                      ring;
    acl_state_t                                 st;
    logic [2:0]                                 port;
    logic [3:0]                                 cnt;
    logic                                       hit;
    logic                                       miss;
  } acl_regs_t;

endpackage

`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the filter-entry indirect access block
// assumes the byte register port and ring inputs all sit on i_clk_sys
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ns;

  logic        i_clk_sys = 1'b0;
  logic        i_rst = 1'b1;
  logic [7:0]  i_reg_addr = 8'h00;
  logic [7:0]  i_reg_wdata = 8'h00;
  logic        i_reg_wr = 1'b0;
  logic        i_reg_rd = 1'b0;
  logic [7:0]  o_reg_rdata;
  logic [2:0]  i_ring_port = 3'h0;
  logic        i_ring_entry_match = 1'b0;
  logic        i_ring_set_match = 1'b0;
  logic        o_ring_hit;
  logic        o_ring_miss;
  int          failures = 0;
  int          tests_run = 0;
  int          cyc = 0;
  int          seed = 1262;
  logic [7:0]  d;
  logic [3:0]  p;
  logic [3:0]  e;
  logic [13:0] m;
  logic        em;
  logic        sm;
  logic [7:0]  h1 [14];
  logic [7:0]  h2 [14];

  acl_entry_access dut_u (
    .i_clk_sys          (i_clk_sys),
    .i_rst              (i_rst),
    .i_reg_addr         (i_reg_addr),
    .i_reg_wdata        (i_reg_wdata),
    .i_reg_wr           (i_reg_wr),
    .i_reg_rd           (i_reg_rd),
    .o_reg_rdata        (o_reg_rdata),
    .i_ring_port        (i_ring_port),
    .i_ring_entry_match (i_ring_entry_match),
    .i_ring_set_match   (i_ring_set_match),
    .o_ring_hit         (o_ring_hit),
    .o_ring_miss        (o_ring_miss)
  );

  always #50 i_clk_sys = ~i_clk_sys;

  // ------------------------------------------------------------
  // checking and bus tasks
  // ------------------------------------------------------------
  task automatic stop_test();
    if (failures == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  // cuts a hung poll or transfer short
  always @(posedge i_clk_sys) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      stop_test();
    end
  end

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s exp=%h seen=%h", nm, exp, seen);
    end
  endtask

  function automatic logic [7:0] exp_byte(input int b);
    return m[13-b] ? h2[b] : h1[b];
  endfunction

  function automatic logic [7:0] ctrl_val(input logic dir, input logic [3:0] idx);
    return {3'b011, dir, idx};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge i_clk_sys);
    i_reg_addr  <= a;
    i_reg_wdata <= v;
    i_reg_wr    <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_wr    <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge i_clk_sys);
    i_reg_addr <= a;
    i_reg_rd   <= 1'b1;
    @(posedge i_clk_sys);
    i_reg_rd   <= 1'b0;
    #1 v = o_reg_rdata;
  endtask

  task automatic sel(input logic [3:0] pt, input logic [7:0] off);
    wr(8'h6e, {4'b0100, pt});
    wr(8'h6f, off);
  endtask

  task automatic iw(input logic [3:0] pt, input logic [7:0] off, input logic [7:0] v);
    sel(pt, off);
    wr(8'ha0, v);
  endtask

  task automatic ir(input logic [3:0] pt, input logic [7:0] off, output logic [7:0] v);
    sel(pt, off);
    rd(8'ha0, v);
  endtask

  // polling stays bounded; a flag that never rises is a mismatch
  task automatic wait_done(input logic [3:0] pt, input int bt);
    int n;
    n = 0;
    d = 8'h00;
    while (d[bt] !== 1'b1 && n < 20) begin
      ir(pt, 8'h12, d);
      n++;
    end
    chk("done_flag", {7'h0, d[bt]}, 8'h01);
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) @(posedge i_clk_sys);
    i_rst <= 1'b0;
    for (int k = 1; k <= 5; k++) begin
      ir(4'(k), 8'h12, d);
      chk("ctrl_reset", d, 8'h60);
      ir(4'(k), 8'h10, d);
      chk("mask_reset", d, 8'h00);
      ir(4'(k), 8'h13, d);
      chk("ring_reset", d, 8'h00);
    end
    wr(8'h6e, 8'h21);
    wr(8'h6f, 8'h10);
    wr(8'ha0, 8'hff);
    rd(8'ha0, d);
    chk("other_table", d, 8'h00);
    wr(8'h6e, 8'h40);
    wr(8'ha0, 8'hff);
    rd(8'ha0, d);
    chk("port_zero", d, 8'h00);
    ir(4'h1, 8'h10, d);
    chk("bad_sel_write", d, 8'h00);
    ir(4'h1, 8'h0e, d);
    chk("unmapped_off", d, 8'h00);
    rd(8'h30, d);
    chk("unmapped_addr", d, 8'h00);
    p = 4'(($unsigned($random(seed)) % 5) + 1);
    e = 4'($random(seed));
    iw(p, 8'h10, 8'hff);
    ir(p, 8'h10, d);
    chk("mask_hi", d, 8'h3f);
    iw(p, 8'h11, 8'hff);
    for (int b = 0; b < 14; b++) begin
      h1[b] = 8'($random(seed));
      iw(p, 8'(b), h1[b]);
    end
    iw(p, 8'h12, {4'h1, e});
    ir(p, 8'h12, d);
    chk("wr_busy", d & 8'h40, 8'h00);
    wr(8'ha0, {4'h0, ~e});
    wait_done(p, 6);
    chk("ctrl_after_wr", d, ctrl_val(1'b1, e));
    m = 14'($random(seed));
    iw(p, 8'h10, {2'b00, m[13:8]});
    iw(p, 8'h11, m[7:0]);
    for (int b = 0; b < 14; b++) begin
      h2[b] = 8'($random(seed));
      iw(p, 8'(b), h2[b]);
    end
    iw(p, 8'h12, {4'h1, e});
    wait_done(p, 6);
    for (int b = 0; b < 14; b++)
      iw(p, 8'(b), 8'h00);
    iw(p, 8'h10, 8'h3f);
    iw(p, 8'h11, 8'hff);
    iw(p, 8'h12, {4'h0, e});
    ir(p, 8'h12, d);
    chk("rd_busy", d & 8'h20, 8'h00);
    wait_done(p, 5);
    chk("ctrl_after_rd", d, ctrl_val(1'b0, e));
    for (int b = 0; b < 14; b++) begin
      ir(p, 8'(b), d);
      chk("entry_byte", d, exp_byte(b));
    end
    for (int f = 1; f >= 0; f--) begin
      iw(p, 8'h13, f[0] ? 8'hff : 8'h00);
      ir(p, 8'h13, d);
      chk("ring_mode", d, {7'h0, f[0]});
      for (int k = 0; k < 24; k++) begin
        em = 1'($random(seed));
        sm = 1'($random(seed));
        @(posedge i_clk_sys);
        i_ring_port        <= 3'(p - 4'h1);
        i_ring_entry_match <= em;
        i_ring_set_match   <= sm;
        @(posedge i_clk_sys);
        #1;
        chk("ring_miss", {7'h0, o_ring_miss}, {7'h0, f[0] & em});
        chk("ring_hit", {7'h0, o_ring_hit}, {7'h0, ~f[0] & sm});
      end
    end
    stop_test();
  end

endmodule

`default_nettype wire
